// file: fp_load_multiple_pkg.sv
/*
 * Shared types and constants for the floating-point load-multiple unit.
 * Assumes a 32-bit memory read port and a 32-bit core register read/write port.
 */
package fp_load_multiple_pkg;

    // ------------------------------------------------------------
    // Instruction field positions
    // ------------------------------------------------------------
    localparam int BEFORE_BIT = 24;
    localparam int UP_BIT = 23;
    localparam int EXTRA_BIT = 22;
    localparam int WBACK_BIT = 21;
    localparam int BASE_LSB = 16;
    localparam int FIRST_LSB = 12;
    localparam int SIZE_BIT = 8;

    // ------------------------------------------------------------
    // Fixed values
    // ------------------------------------------------------------
    localparam logic [3:0] STACK_PTR_IDX = 4'hd;
    localparam logic [3:0] PC_IDX = 4'hf;
    localparam logic [8:0] MAX_DREGS = 9'h010;
    localparam logic [8:0] REG_LIMIT = 9'h020;
    localparam logic [8:0] SMALL_LIMIT = 9'h010;
    localparam logic [31:0] WORD_STEP = 32'h0000_0004;
    localparam logic [3:0] IRQ_RESET = 4'h0;

    // ------------------------------------------------------------
    // Decode outcomes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        DEC_EXECUTE,
        DEC_RELATED_XFER,
        DEC_STACK_POP,
        DEC_SINGLE_LOAD,
        DEC_LEGACY_EXT,
        DEC_UNDEFINED,
        DEC_UNPREDICTABLE
    } dec_kind_t;

    // Memory read request
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
    } mem_req_t;

    // Extension register write
    typedef struct packed {
        logic valid;
        logic dbl;
        logic [4:0] idx;
        logic [63:0] data;
    } ext_wr_t;

endpackage : fp_load_multiple_pkg

// file: fp_load_multiple_unit.sv
/*
 * Decode, check and sequencer for the floating-point load-multiple instruction.
 * Assumes the fetch side holds instr_valid until instr_ready, the base value
 * is read combinationally by the caller and presented with the instruction,
 * and memory returns one word per request with a one-cycle rvalid pulse.
 */
`timescale 1ns/1ps
module fp_load_multiple_unit (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic instr_valid,
    input wire logic [31:0] instr_word,
    input wire logic [31:0] base_value,
    input wire logic cond_pass,
    input wire logic fp_access_ok,
    input wire logic big_endian,
    input wire logic small_bank,
    output logic instr_ready,
    output logic [2:0] dec_kind,
    output logic dec_strobe,
    output fp_load_multiple_pkg::mem_req_t mem_req,
    input wire logic mem_rvalid,
    input wire logic [31:0] mem_rdata,
    output fp_load_multiple_pkg::ext_wr_t ext_wr,
    output logic base_wr_valid,
    output logic [3:0] base_wr_idx,
    output logic [31:0] base_wr_data,
    output logic busy,
    // Register bus for interrupt status/mask
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);

    localparam logic [11:0] STATUS_OFS = 12'h000;
    localparam logic [11:0] MASK_OFS = 12'h004;

    typedef enum logic [1:0] {S_IDLE, S_READ, S_WAIT, S_DONE} state_t;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function automatic fp_load_multiple_pkg::dec_kind_t classify(
        input logic [31:0] w, input logic sb);
        logic p;
        logic u;
        logic wb;
        logic dbl;
        logic [8:0] regs;
        logic [8:0] first;
        p = w[fp_load_multiple_pkg::BEFORE_BIT];
        u = w[fp_load_multiple_pkg::UP_BIT];
        wb = w[fp_load_multiple_pkg::WBACK_BIT];
        dbl = w[fp_load_multiple_pkg::SIZE_BIT];
        regs = dbl ? {2'h0, w[7:1]} : {1'h0, w[7:0]};
        first = dbl ? {4'h0, w[22], w[15:12]} : {4'h0, w[15:12], w[22]};
        if (!p && !u && !wb)
            classify = fp_load_multiple_pkg::DEC_RELATED_XFER;
        else if (!p && u && wb && w[19:16] == fp_load_multiple_pkg::STACK_PTR_IDX)
            classify = fp_load_multiple_pkg::DEC_STACK_POP;
        else if (p && !wb)
            classify = fp_load_multiple_pkg::DEC_SINGLE_LOAD;
        else if (dbl && w[0])
            classify = fp_load_multiple_pkg::DEC_LEGACY_EXT;
        else if (p == u && wb)
            classify = fp_load_multiple_pkg::DEC_UNDEFINED;
        else if (w[19:16] == fp_load_multiple_pkg::PC_IDX)
            classify = fp_load_multiple_pkg::DEC_UNDEFINED;
        else if (regs == 9'h000 || first + regs > fp_load_multiple_pkg::REG_LIMIT)
            classify = fp_load_multiple_pkg::DEC_UNPREDICTABLE;
        else if (dbl && regs > fp_load_multiple_pkg::MAX_DREGS)
            classify = fp_load_multiple_pkg::DEC_UNPREDICTABLE;
        else if (dbl && sb && first + regs > fp_load_multiple_pkg::SMALL_LIMIT)
            classify = fp_load_multiple_pkg::DEC_UNPREDICTABLE;
        else
            classify = fp_load_multiple_pkg::DEC_EXECUTE;
    endfunction : classify

    fp_load_multiple_pkg::dec_kind_t kind;
    logic w_dbl;
    logic [7:0] w_count;
    logic [4:0] w_first;
    logic [31:0] w_bytes;

    // Field extraction of the presented word
    always_comb begin
        kind = classify(instr_word, small_bank);
        w_dbl = instr_word[fp_load_multiple_pkg::SIZE_BIT];
        w_count = w_dbl ? {1'h0, instr_word[7:1]} : instr_word[7:0];
        w_first = w_dbl ? {instr_word[22], instr_word[15:12]}
                        : {instr_word[15:12], instr_word[22]};
        w_bytes = {22'h0, instr_word[7:0], 2'h0};
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    state_t state_q;
    logic dbl_q;
    logic be_q;
    logic half_q;
    logic [7:0] left_q;
    logic [4:0] idx_q;
    logic [31:0] addr_q;
    logic [31:0] first_word_q;
    logic accept;
    logic done_pulse;
    logic undef_pulse;

    // Checks gate memory and register effects: a failed condition only sets status bit 3
    // Ready still stands while the word is held, so it is not taken twice
    assign accept = instr_valid && !instr_ready && state_q == S_IDLE;
    assign done_pulse = state_q == S_DONE;
    assign undef_pulse = accept && cond_pass && fp_access_ok
        && (kind == fp_load_multiple_pkg::DEC_UNDEFINED
            || kind == fp_load_multiple_pkg::DEC_UNPREDICTABLE);

    // Instruction acceptance and word stepping
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= S_IDLE;
            dbl_q <= 1'b0;
            be_q <= 1'b0;
            half_q <= 1'b0;
            left_q <= 8'h00;
            idx_q <= 5'h00;
            addr_q <= 32'h0000_0000;
            first_word_q <= 32'h0000_0000;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (accept && cond_pass && fp_access_ok
                        && kind == fp_load_multiple_pkg::DEC_EXECUTE) begin
                        state_q <= S_READ;
                        dbl_q <= w_dbl;
                        be_q <= big_endian;
                        half_q <= 1'b0;
                        left_q <= w_count;
                        idx_q <= w_first;
                        addr_q <= instr_word[fp_load_multiple_pkg::UP_BIT]
                            ? base_value : base_value - w_bytes;
                    end
                end
                S_READ: state_q <= S_WAIT;
                S_WAIT: begin
                    if (mem_rvalid) begin
                        addr_q <= addr_q + fp_load_multiple_pkg::WORD_STEP;
                        if (dbl_q && !half_q) begin
                            first_word_q <= mem_rdata;
                            half_q <= 1'b1;
                            state_q <= S_READ;
                        end else begin
                            half_q <= 1'b0;
                            idx_q <= idx_q + 5'h01;
                            left_q <= left_q - 8'h01;
                            state_q <= (left_q == 8'h01) ? S_DONE : S_READ;
                        end
                    end
                end
                S_DONE: state_q <= S_IDLE;
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // Registered outputs toward memory, register files and fetch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_req <= '0;
            ext_wr <= '0;
            base_wr_valid <= 1'b0;
            base_wr_idx <= 4'h0;
            base_wr_data <= 32'h0000_0000;
            instr_ready <= 1'b0;
            dec_kind <= 3'h0;
            dec_strobe <= 1'b0;
            busy <= 1'b0;
        end else begin
            mem_req.valid <= state_q == S_READ;
            mem_req.addr <= addr_q;
            busy <= state_q != S_IDLE || (accept && kind == fp_load_multiple_pkg::DEC_EXECUTE);
            instr_ready <= accept;
            dec_strobe <= accept;
            dec_kind <= 3'(kind);
            ext_wr.valid <= state_q == S_WAIT && mem_rvalid && !(dbl_q && !half_q);
            ext_wr.dbl <= dbl_q;
            ext_wr.idx <= idx_q;
            if (dbl_q)
                ext_wr.data <= be_q ? {first_word_q, mem_rdata}
                                    : {mem_rdata, first_word_q};
            else
                ext_wr.data <= {32'h0000_0000, mem_rdata};
            // Writeback at acceptance; the base value was sampled then too
            base_wr_valid <= accept && cond_pass && fp_access_ok
                && kind == fp_load_multiple_pkg::DEC_EXECUTE
                && instr_word[fp_load_multiple_pkg::WBACK_BIT];
            base_wr_idx <= instr_word[19:16];
            base_wr_data <= instr_word[fp_load_multiple_pkg::UP_BIT]
                ? base_value + w_bytes : base_value - w_bytes;
        end
    end

    // ------------------------------------------------------------
    // Interrupt status and APB slave
    // ------------------------------------------------------------
    // Bit 0 done, bit 1 undefined, bit 2 unpredictable-as-undefined, bit 3 rejected check
    logic [3:0] status_q;
    logic [3:0] mask_q;
    logic [3:0] events;
    logic wr_en;

    assign wr_en = psel && penable && pwrite;
    assign events = {accept && (!cond_pass || !fp_access_ok),
                     undef_pulse && kind == fp_load_multiple_pkg::DEC_UNPREDICTABLE,
                     undef_pulse && kind == fp_load_multiple_pkg::DEC_UNDEFINED,
                     done_pulse};

    // Sticky bits: a new event wins over a clearing write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= fp_load_multiple_pkg::IRQ_RESET;
            mask_q <= fp_load_multiple_pkg::IRQ_RESET;
        end else begin
            if (wr_en && paddr == MASK_OFS)
                mask_q <= pwdata[3:0];
            if (wr_en && paddr == STATUS_OFS)
                status_q <= (status_q & ~pwdata[3:0]) | events;
            else
                status_q <= status_q | events;
        end
    end

    // Zero-wait slave; unmapped addresses answer with an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            irq <= 1'b0;
        end else begin
            irq <= |(status_q & mask_q);
            pready <= psel && !penable;
            pslverr <= psel && !penable && paddr != STATUS_OFS && paddr != MASK_OFS;
            if (psel && !penable && !pwrite)
                prdata <= (paddr == STATUS_OFS) ? {28'h0, status_q}
                        : (paddr == MASK_OFS) ? {28'h0, mask_q} : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Control bits of the presented word, named for the checks
    logic before_set;
    logic up_set;
    logic wback_set;
    logic [3:0] base_reg_field;
    assign before_set = instr_word[fp_load_multiple_pkg::BEFORE_BIT];
    assign up_set = instr_word[fp_load_multiple_pkg::UP_BIT];
    assign wback_set = instr_word[fp_load_multiple_pkg::WBACK_BIT];
    assign base_reg_field = instr_word[fp_load_multiple_pkg::BASE_LSB +: 4];

    a_zero_related: assert property (@(posedge pclk) disable iff (!presetn)
        accept && !before_set && !up_set && !wback_set
        |-> kind == fp_load_multiple_pkg::DEC_RELATED_XFER)
        else $error("related transfer word not handed on");
    a_stack_pop: assert property (@(posedge pclk) disable iff (!presetn)
        accept && !before_set && up_set && wback_set
        && base_reg_field == fp_load_multiple_pkg::STACK_PTR_IDX
        |-> kind == fp_load_multiple_pkg::DEC_STACK_POP)
        else $error("stack pop form missed");
    a_single_load: assert property (@(posedge pclk) disable iff (!presetn)
        accept && before_set && !wback_set
        |-> kind == fp_load_multiple_pkg::DEC_SINGLE_LOAD)
        else $error("single load form missed");
    a_legacy_ext: assert property (@(posedge pclk) disable iff (!presetn)
        accept && kind == fp_load_multiple_pkg::DEC_EXECUTE
        |-> !(w_dbl && instr_word[0]))
        else $error("odd count double form executed");
    a_no_undef_exec: assert property (@(posedge pclk) disable iff (!presetn)
        accept && before_set == up_set && wback_set
        |-> kind != fp_load_multiple_pkg::DEC_EXECUTE)
        else $error("undefined combination executed");
    a_exec_modes: assert property (@(posedge pclk) disable iff (!presetn)
        accept && kind == fp_load_multiple_pkg::DEC_EXECUTE
        |-> {before_set, up_set, wback_set} inside {3'h2, 3'h3, 3'h5})
        else $error("unlisted addressing mode executed");
    a_pc_base: assert property (@(posedge pclk) disable iff (!presetn)
        accept && base_reg_field == fp_load_multiple_pkg::PC_IDX
        |-> kind != fp_load_multiple_pkg::DEC_EXECUTE)
        else $error("program counter base executed");
    a_count_bound: assert property (@(posedge pclk) disable iff (!presetn)
        accept && kind == fp_load_multiple_pkg::DEC_EXECUTE
        |-> w_count != 8'h00
            && {4'h0, w_first} + {1'h0, w_count} <= fp_load_multiple_pkg::REG_LIMIT)
        else $error("register range out of bounds executed");
    a_dbl_count: assert property (@(posedge pclk) disable iff (!presetn)
        accept && kind == fp_load_multiple_pkg::DEC_EXECUTE && w_dbl
        |-> {1'h0, w_count} <= fp_load_multiple_pkg::MAX_DREGS)
        else $error("too many double registers executed");
    a_small_bank: assert property (@(posedge pclk) disable iff (!presetn)
        accept && kind == fp_load_multiple_pkg::DEC_EXECUTE && w_dbl && small_bank
        |-> {4'h0, w_first} + {1'h0, w_count} <= fp_load_multiple_pkg::SMALL_LIMIT)
        else $error("small bank overrun executed");
    a_check_gate: assert property (@(posedge pclk) disable iff (!presetn)
        accept && !(cond_pass && fp_access_ok) |=> !base_wr_valid && state_q == S_IDLE)
        else $error("effect after failed check");
    a_start_addr: assert property (@(posedge pclk) disable iff (!presetn)
        accept && cond_pass && fp_access_ok && kind == fp_load_multiple_pkg::DEC_EXECUTE
        |=> addr_q == ($past(up_set) ? $past(base_value)
                                     : $past(base_value) - $past(w_bytes)))
        else $error("start address wrong");
    a_wback_value: assert property (@(posedge pclk) disable iff (!presetn)
        accept && cond_pass && fp_access_ok && kind == fp_load_multiple_pkg::DEC_EXECUTE
        && wback_set |=> base_wr_valid && base_wr_data == ($past(up_set)
            ? $past(base_value) + $past(w_bytes) : $past(base_value) - $past(w_bytes)))
        else $error("written back base wrong");
    a_word_step: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == S_WAIT && mem_rvalid
        |=> addr_q == $past(addr_q) + fp_load_multiple_pkg::WORD_STEP)
        else $error("address step wrong");
    a_req_follows: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == S_READ |=> mem_req.valid && mem_req.addr == $past(addr_q))
        else $error("read not issued");
    // A double register asks for its second word right after the first
    sequence s_first_half;
        state_q == S_WAIT && mem_rvalid && dbl_q && !half_q;
    endsequence
    sequence s_second_req;
        state_q == S_READ ##1 mem_req.valid;
    endsequence
    a_dbl_pair: assert property (@(posedge pclk) disable iff (!presetn)
        s_first_half |=> s_second_req)
        else $error("second word of a double not requested");
endmodule : fp_load_multiple_unit

// file: fp_load_multiple_unit_tb_top.sv
/* Bench for the load-multiple unit: decode table, transfers, failed checks
   and interrupt registers. Assumes fp_mem_model stands in for memory. */
`timescale 1ns/1ps
module fp_load_multiple_unit_tb_top;
    logic pclk = 1'b0, presetn = 1'b0, instr_valid = 1'b0, cond_pass = 1'b1;
    logic fp_access_ok = 1'b1, big_endian = 1'b0, small_bank = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] instr_word = 32'h0, base_value = 32'h0, pwdata = 32'h0;
    logic instr_ready, dec_strobe, mem_rvalid, base_wr_valid, busy, pready, pslverr, irq, err;
    logic [2:0] dec_kind, kind_seen;
    logic [3:0] base_wr_idx;
    logic [31:0] mem_rdata, base_wr_data, prdata, rd;
    fp_load_multiple_pkg::mem_req_t mem_req;
    fp_load_multiple_pkg::ext_wr_t ext_wr;
    fp_load_multiple_pkg::ext_wr_t wq[$];
    logic [35:0] bq[$];
    int failures = 0, tests_run = 0, nreq = 0, nq;

    fp_load_multiple_unit u_dut (.pclk(pclk), .presetn(presetn), .instr_valid(instr_valid),
        .instr_word(instr_word), .base_value(base_value), .cond_pass(cond_pass),
        .fp_access_ok(fp_access_ok), .big_endian(big_endian), .small_bank(small_bank),
        .instr_ready(instr_ready), .dec_kind(dec_kind), .dec_strobe(dec_strobe),
        .mem_req(mem_req), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .ext_wr(ext_wr),
        .base_wr_valid(base_wr_valid), .base_wr_idx(base_wr_idx), .base_wr_data(base_wr_data),
        .busy(busy), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
    fp_mem_model u_mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
        .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));

    // ------------------------------------
    // Clock, monitors and helpers
    // ------------------------------------
    initial begin
        forever #50 pclk = ~pclk;
    end
    // Pulses are caught at the edge they stand on
    always @(posedge pclk) begin
        if (ext_wr.valid === 1'b1) wq.push_back(ext_wr);
        if (base_wr_valid === 1'b1) bq.push_back({base_wr_idx, base_wr_data});
        if (mem_req.valid === 1'b1) nreq++;
        if (dec_strobe === 1'b1) kind_seen = dec_kind;
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : test_done
    // Watchdog far beyond the few hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        test_done();
    end
    // Bus cycle: setup, then access until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        check(pready, 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // The registered irq trails a register write by one more edge
        repeat (2) @(posedge pclk);
    endtask : apb
    function automatic logic [31:0] enc(input logic [2:0] puw, input logic d,
        input logic [3:0] rn, input logic [3:0] vd, input logic sz, input logic [7:0] imm);
        return {7'h76, puw[2:1], d, puw[0], 1'b1, rn, vd, 3'h5, sz, imm};
    endfunction : enc
    // Hold the word until taken, then wait for the unit to go idle
    task automatic issue(input logic [31:0] w, input logic [31:0] b, input logic c,
        input logic f);
        int n;
        n = 0;
        instr_word <= w;
        base_value <= b;
        cond_pass <= c;
        fp_access_ok <= f;
        instr_valid <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (instr_ready !== 1'b1 && n < 50);
        check(instr_ready, 1'b1);
        instr_valid <= 1'b0;
        repeat (2) @(posedge pclk);
        while (busy !== 1'b0 && n < 400) begin
            @(posedge pclk);
            n++;
        end
        check(busy, 1'b0);
        repeat (3) @(posedge pclk);
    endtask : issue
    task automatic dec(input logic [31:0] w, input logic [2:0] k);
        kind_seen = 3'h7;
        issue(w, 32'h1000, 1'b1, 1'b1);
        check(kind_seen, k);
    endtask : dec
    task automatic exec(input logic [31:0] w, input logic [31:0] b, input logic dbl,
        input int n, input logic [4:0] d0, input logic [31:0] start, input logic [35:0] bexp);
        logic [31:0] a;
        logic [63:0] e;
        wq.delete();
        bq.delete();
        issue(w, b, 1'b1, 1'b1);
        check(64'(wq.size()), 64'(n));
        check(64'(bq.size()), 64'(bexp != 36'h0));
        if (bq.size() > 0) check(bq[0], bexp);
        a = start;
        foreach (wq[i]) begin
            check({wq[i].dbl, wq[i].idx}, {dbl, d0 + 5'(i)});
            if (dbl) e = big_endian ? {u_mem.word_at(a), u_mem.word_at(a + 32'h4)}
                                    : {u_mem.word_at(a + 32'h4), u_mem.word_at(a)};
            else e = {32'h0, u_mem.word_at(a)};
            check(dbl ? wq[i].data : {32'h0, wq[i].data[31:0]}, e);
            a = a + (dbl ? 32'h8 : 32'h4);
        end
    endtask : exec

    // ------------------------------------
    // Test sequence
    // ------------------------------------
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 12'h000, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        check({irq, rd}, 33'h0);
        $display("test reset done");
        dec(enc(3'b000, 1'b0, 4'h1, 4'h0, 1'b1, 8'h04), 3'd1);
        dec(enc(3'b011, 1'b0, 4'hd, 4'h0, 1'b1, 8'h04), 3'd2);
        dec(enc(3'b100, 1'b0, 4'h1, 4'h0, 1'b0, 8'h04), 3'd3);
        dec(enc(3'b110, 1'b0, 4'h1, 4'h0, 1'b1, 8'h04), 3'd3);
        dec(enc(3'b010, 1'b0, 4'h1, 4'h0, 1'b1, 8'h05), 3'd4);
        dec(enc(3'b111, 1'b0, 4'h1, 4'h0, 1'b1, 8'h04), 3'd5);
        dec(enc(3'b001, 1'b0, 4'h1, 4'h0, 1'b0, 8'h04), 3'd5);
        dec(enc(3'b010, 1'b0, 4'hf, 4'h0, 1'b1, 8'h04), 3'd5);
        dec(enc(3'b010, 1'b0, 4'h1, 4'h0, 1'b1, 8'h00), 3'd6);
        dec(enc(3'b010, 1'b0, 4'h1, 4'h0, 1'b1, 8'h22), 3'd6);
        dec(enc(3'b010, 1'b1, 4'h1, 4'hf, 1'b1, 8'h04), 3'd6);
        dec(enc(3'b010, 1'b0, 4'h1, 4'h0, 1'b0, 8'h00), 3'd6);
        dec(enc(3'b010, 1'b1, 4'h1, 4'hf, 1'b0, 8'h02), 3'd6);
        small_bank <= 1'b1;
        dec(enc(3'b010, 1'b0, 4'h1, 4'he, 1'b1, 8'h06), 3'd6);
        small_bank <= 1'b0;
        check(64'(nreq + bq.size()), 64'h0);
        $display("test decode done");
        exec(enc(3'b010, 1'b1, 4'h3, 4'he, 1'b0, 8'h03), 32'h1000, 1'b0, 3, 5'd29,
            32'h1000, 36'h0);
        exec(enc(3'b101, 1'b0, 4'h5, 4'h2, 1'b0, 8'h02), 32'h2000, 1'b0, 2, 5'd4,
            32'h1ff8, {4'h5, 32'h1ff8});
        u_mem.lat = 2;
        big_endian <= 1'b1;
        exec(enc(3'b011, 1'b1, 4'h2, 4'he, 1'b1, 8'h04), 32'h400, 1'b1, 2, 5'd30,
            32'h400, {4'h2, 32'h410});
        u_mem.lat = 0;
        big_endian <= 1'b0;
        small_bank <= 1'b1;
        exec(enc(3'b101, 1'b0, 4'h7, 4'he, 1'b1, 8'h04), 32'h3000, 1'b1, 2, 5'd14,
            32'h2ff0, {4'h7, 32'h2ff0});
        small_bank <= 1'b0;
        $display("test transfer done");
        for (int i = 0; i < 2; i++) begin
            nq = nreq;
            wq.delete();
            bq.delete();
            issue(enc(3'b011, 1'b0, 4'h1, 4'h0, 1'b0, 8'h02), 32'h500, i[0], !i[0]);
            check(64'(nreq - nq + wq.size() + bq.size()), 64'h0);
        end
        $display("test check failure done");
        apb(1'b0, 12'h000, 32'h0);
        check({err, rd}, 33'h0_0000_000f);
        apb(1'b1, 12'h004, 32'h1);
        check(irq, 1'b1);
        apb(1'b1, 12'h000, 32'h1);
        check(irq, 1'b0);
        apb(1'b0, 12'h000, 32'h0);
        check(rd, 32'he);
        apb(1'b1, 12'h004, 32'h2);
        check(irq, 1'b1);
        apb(1'b1, 12'h004, 32'h0);
        check(irq, 1'b0);
        apb(1'b0, 12'h010, 32'h0);
        check(err, 1'b1);
        $display("test interrupt done");
        test_done();
    end
endmodule : fp_load_multiple_unit_tb_top

// file: fp_mem_model.sv
/* Memory read partner for the load-multiple unit.
   Assumes at most one word request outstanding at a time. */
`timescale 1ns/1ps
module fp_mem_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire fp_load_multiple_pkg::mem_req_t mem_req,
    output logic mem_rvalid,
    output logic [31:0] mem_rdata
);
    int lat = 0;
    int cnt;
    logic [31:0] addr_q;
    // Content tied to the low 16 address bits, so an address wrong in those bits reads wrong data
    function automatic logic [31:0] word_at(input logic [31:0] a);
        return {a[15:0] ^ 16'h5a3c, a[15:0]};
    endfunction : word_at
    // ------------------------------------
    // Answer after lat extra cycles
    // ------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_rvalid <= 1'b0;
            mem_rdata <= 32'h0;
            cnt <= 0;
            addr_q <= 32'h0;
        end else begin
            mem_rvalid <= 1'b0;
            mem_rdata <= ~mem_rdata; // Inverted each cycle outside the pulse, so the last word reappears every other cycle
            if (mem_req.valid && lat == 0) begin
                mem_rvalid <= 1'b1;
                mem_rdata <= word_at(mem_req.addr);
            end else if (mem_req.valid) begin
                addr_q <= mem_req.addr;
                cnt <= lat;
            end else if (cnt > 1) begin
                cnt <= cnt - 1;
            end else if (cnt == 1) begin
                cnt <= 0;
                mem_rvalid <= 1'b1;
                mem_rdata <= word_at(addr_q);
            end
        end
    end
endmodule : fp_mem_model
